//--- irq_thr_pkg.sv
// constants, register map and types of the interrupt and threshold unit
package irq_thr_pkg;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int IDX_W = 6;
    localparam int ADDR_LSB = 2;

    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CTRL = 6'h02;
    localparam logic [IDX_W-1:0] IDX_MASK = 6'h03;
    localparam logic [IDX_W-1:0] IDX_FLAGS = 6'h04;
    localparam logic [IDX_W-1:0] IDX_VOLTAGE = 6'h1D;
    localparam logic [IDX_W-1:0] IDX_THR_LEVEL = 6'h2B;
    localparam logic [IDX_W-1:0] IDX_THR_CTRL = 6'h2C;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h2D;
    localparam logic [IDX_W-1:0] IDX_CURRENT = 6'h2E;

    // control register fields
    localparam int CTRL_IRQ_EN_BIT = 7;
    localparam int CTRL_IRQ_POL_BIT = 6;
    localparam logic [REG_W-1:0] CTRL_WMASK = 8'hC0;

    // threshold control fields
    localparam int THR_DIR_BIT = 0;
    localparam int THR_MASK_BIT = 1;
    localparam int THR_SRC_BIT = 2;
    localparam int THR_FLAG_BIT = 3;
    localparam logic [REG_W-1:0] THR_CTRL_WMASK = 8'h07;

    // status fields
    localparam int STAT_PEND_BIT = 0;
    localparam int STAT_PIN_BIT = 1;
    localparam int STAT_CAP_BIT = 2;
    localparam int STAT_ABOVE_BIT = 3;

    // flag bit fed by the line polarity detector, sign bit of the reading
    localparam int POL_FLAG_BIT = 0;
    localparam int LV_SIGN_BIT = 7;

    // reset values
    localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [REG_W-1:0] MASK_RESET = 8'h00;
    localparam logic [REG_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [REG_W-1:0] THR_LEVEL_RESET = 8'h00;
    localparam logic [REG_W-1:0] THR_CTRL_RESET = 8'h00;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // write channel states
    typedef enum logic [0:0] {
        WR_COLLECT = 1'b0,
        WR_RESP = 1'b1
    } wr_state_t;

endpackage : irq_thr_pkg

//--- irq_thr_unit.sv
// interrupt collector, threshold comparator and shared pin driver
//
// Behaviour
// - with interrupt enable set, shared pin carries the request, not the monitor
// - request is active low after reset, active high when polarity bit is one
// - in interrupt mode the pin is open drain, driving only the active level
// - eight source mask bits plus a threshold mask; only masked-in sources assert
// - lowest mask and threshold compare act only with a capable line side
// - request stays active until every pending enabled flag is cleared
// - every event flag, threshold flag too, latches until serviced
// - threshold fires on crossing the 8-bit level; select picks voltage or current
// - direction bit picks rising above or falling below the level
// - comparison uses the magnitude only, sign of voltage ignored
// - voltage reading is 8-bit two's complement, top bit is polarity
// - a sticky flag clears only when software writes zero to it
// - fine current reading counts 1.1 mA per code, valid when off hook
`timescale 1ns/10ps

module irq_thr_unit
    import irq_thr_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    // register bus, axi4-lite slave
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W/8-1:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // device side event sources and readings
    input wire logic [7:1] source_events,
    input wire logic [REG_W-1:0] line_voltage_reading,
    input wire logic [REG_W-1:0] fine_loop_current_reading,
    input wire logic off_hook,
    input wire logic monitor_pwm,
    input wire logic line_side_capable,
    // shared monitor or interrupt pin
    input wire logic monitor_or_irq_pin_i,
    output logic monitor_or_irq_pin_o,
    output logic monitor_or_irq_pin_oe
);

    // all state of the unit
    typedef struct packed {
        wr_state_t wr_state;
        logic aw_held;
        logic w_held;
        logic [IDX_W-1:0] wr_idx;
        logic [REG_W-1:0] wr_data;
        logic wr_lane0;
        logic [1:0] bresp;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic [REG_W-1:0] ctrl;
        logic [REG_W-1:0] mask;
        logic [REG_W-1:0] flags;
        logic [REG_W-1:0] thr_level;
        logic [REG_W-1:0] thr_ctrl;
        logic cap_meta;
        logic cap_sync;
        logic pin_meta;
        logic pin_sync;
        logic sign_prev;
        logic sign_seen;
        logic above_prev;
        logic above_valid;
        logic pin_o;
        logic pin_oe;
    } st_t;

    localparam st_t ST_RESET = '{
        wr_state: WR_COLLECT,
        ctrl: CTRL_RESET,
        mask: MASK_RESET,
        flags: FLAGS_RESET,
        thr_level: THR_LEVEL_RESET,
        thr_ctrl: THR_CTRL_RESET,
        default: '0
    };

    st_t st_q;
    st_t st_d;

    logic capable;
    logic wr_fire;
    logic wr_flags;
    logic wr_thr_ctrl;
    logic [REG_W-1:0] volt_mag;
    logic [REG_W-1:0] sel_mag;
    logic cmp_valid;
    logic above_now;
    logic thr_cross;
    logic pol_change;
    logic [REG_W-1:0] src_set;
    logic [REG_W-1:0] flag_clr;
    logic [REG_W-1:0] flags_next;
    logic [REG_W-1:0] mask_eff;
    logic thr_flag_next;
    logic pending;
    logic [IDX_W-1:0] rd_idx;
    logic [REG_W-1:0] rd_val;
    logic rd_hit;

    // capable strap after its synchroniser
    assign capable = st_q.cap_sync;

    // bus handshakes, one write and one read at a time
    assign awready = (st_q.wr_state == WR_COLLECT) && !st_q.aw_held;
    assign wready = (st_q.wr_state == WR_COLLECT) && !st_q.w_held;
    assign bvalid = (st_q.wr_state == WR_RESP);
    assign bresp = st_q.bresp;
    assign arready = !st_q.rvalid;
    assign rvalid = st_q.rvalid;
    assign rdata = st_q.rdata;
    assign rresp = st_q.rresp;

    // write is carried out once address and data are both held
    assign wr_fire = st_q.aw_held && st_q.w_held
        && (st_q.wr_state == WR_COLLECT);
    assign wr_flags = wr_fire && st_q.wr_lane0
        && (st_q.wr_idx == IDX_FLAGS);
    assign wr_thr_ctrl = wr_fire && st_q.wr_lane0
        && (st_q.wr_idx == IDX_THR_CTRL);

    // magnitude of the signed voltage, sign dropped
    assign volt_mag = line_voltage_reading[LV_SIGN_BIT]
        ? (~line_voltage_reading + 8'h01)
        : line_voltage_reading;

    // source select, current only counts while off hook
    assign sel_mag = st_q.thr_ctrl[THR_SRC_BIT]
        ? fine_loop_current_reading : volt_mag;
    assign cmp_valid = capable
        && (!st_q.thr_ctrl[THR_SRC_BIT] || off_hook);
    assign above_now = sel_mag > st_q.thr_level;

    // crossing in the chosen direction against the kept result
    assign thr_cross = cmp_valid && st_q.above_valid
        && (st_q.thr_ctrl[THR_DIR_BIT]
            ? (above_now && !st_q.above_prev)
            : (!above_now && st_q.above_prev));

    // line polarity change from the sign of the voltage reading
    assign pol_change = capable && st_q.sign_seen
        && (line_voltage_reading[LV_SIGN_BIT] != st_q.sign_prev);

    // set sources: bit 0 is the polarity detector
    assign src_set = {source_events, pol_change};

    // a written zero clears, a written one leaves the flag alone
    assign flag_clr = wr_flags ? ~st_q.wr_data : 8'h00;

    // per flag: set wins over a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < REG_W; gi++) begin : g_flag
            assign flags_next[gi] = src_set[gi]
                || (st_q.flags[gi] && !flag_clr[gi]);
        end
    endgenerate

    // threshold flag is sticky as well, cleared by a written zero
    assign thr_flag_next = thr_cross
        || (st_q.thr_ctrl[THR_FLAG_BIT]
            && !(wr_thr_ctrl && !st_q.wr_data[THR_FLAG_BIT]));

    // lowest mask only counts with a capable line side
    assign mask_eff = {st_q.mask[7:1], st_q.mask[0] && capable};

    // request stays up while any enabled flag is pending
    assign pending = (|(st_q.flags & mask_eff))
        || (st_q.thr_ctrl[THR_FLAG_BIT] && st_q.thr_ctrl[THR_MASK_BIT]
            && capable);

    // read decode, flags readable for polling without side effect
    assign rd_idx = araddr[ADDR_LSB+IDX_W-1:ADDR_LSB];

    always_comb begin : read_mux
        rd_val = 8'h00;
        rd_hit = 1'b1;
        case (rd_idx)
            IDX_CTRL: begin
                rd_val = st_q.ctrl;
            end
            IDX_MASK: begin
                rd_val = st_q.mask;
            end
            IDX_FLAGS: begin
                rd_val = st_q.flags;
            end
            IDX_VOLTAGE: begin
                rd_val = line_voltage_reading;
            end
            IDX_THR_LEVEL: begin
                rd_val = st_q.thr_level;
            end
            IDX_THR_CTRL: begin
                rd_val = st_q.thr_ctrl;
            end
            IDX_STATUS: begin
                rd_val[STAT_PEND_BIT] = pending;
                rd_val[STAT_PIN_BIT] = st_q.pin_sync;
                rd_val[STAT_CAP_BIT] = capable;
                rd_val[STAT_ABOVE_BIT] = st_q.above_prev;
            end
            IDX_CURRENT: begin
                rd_val = fine_loop_current_reading;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // next state of the whole unit
    always_comb begin : next_state
        st_d = st_q;

        // two flip-flop synchronisers for the strap and the pin level
        st_d.cap_meta = line_side_capable;
        st_d.cap_sync = st_q.cap_meta;
        st_d.pin_meta = monitor_or_irq_pin_i;
        st_d.pin_sync = st_q.pin_meta;

        // write address and data taken in either order
        if (awvalid && awready) begin
            st_d.aw_held = 1'b1;
            st_d.wr_idx = awaddr[ADDR_LSB+IDX_W-1:ADDR_LSB];
        end
        if (wvalid && wready) begin
            st_d.w_held = 1'b1;
            st_d.wr_data = wdata[REG_W-1:0];
            st_d.wr_lane0 = wstrb[0];
        end

        // write channel state machine
        case (st_q.wr_state)
            WR_COLLECT: begin
                if (wr_fire) begin
                    st_d.wr_state = WR_RESP;
                    st_d.bresp = RESP_OKAY;
                    case (st_q.wr_idx)
                        IDX_CTRL, IDX_MASK, IDX_FLAGS, IDX_THR_LEVEL,
                        IDX_THR_CTRL, IDX_VOLTAGE, IDX_STATUS,
                        IDX_CURRENT: begin
                            st_d.bresp = RESP_OKAY;
                        end
                        default: begin
                            st_d.bresp = RESP_SLVERR;
                        end
                    endcase
                end
            end
            WR_RESP: begin
                if (bready) begin
                    st_d.wr_state = WR_COLLECT;
                    st_d.aw_held = 1'b0;
                    st_d.w_held = 1'b0;
                end
            end
            default: begin
                st_d.wr_state = WR_COLLECT;
                st_d.aw_held = 1'b0;
                st_d.w_held = 1'b0;
            end
        endcase

        // plain control registers, lane 0 carries the byte
        if (wr_fire && st_q.wr_lane0) begin
            case (st_q.wr_idx)
                IDX_CTRL: begin
                    st_d.ctrl = st_q.wr_data & CTRL_WMASK;
                end
                IDX_MASK: begin
                    st_d.mask = st_q.wr_data;
                end
                IDX_THR_LEVEL: begin
                    st_d.thr_level = st_q.wr_data;
                end
                IDX_THR_CTRL: begin
                    st_d.thr_ctrl = st_q.wr_data & THR_CTRL_WMASK;
                end
                default: begin
                    st_d.ctrl = st_q.ctrl;
                end
            endcase
        end

        // sticky flags, merged after the control write
        st_d.flags = flags_next;
        st_d.thr_ctrl[THR_FLAG_BIT] = thr_flag_next;

        // read channel, data captured when the address is taken
        if (arvalid && arready) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = {24'h000000, rd_val};
            st_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (st_q.rvalid && rready) begin
            st_d.rvalid = 1'b0;
        end

        // sign tracker, idle without a capable line side
        if (capable) begin
            st_d.sign_prev = line_voltage_reading[LV_SIGN_BIT];
            st_d.sign_seen = 1'b1;
        end else begin
            st_d.sign_seen = 1'b0;
        end

        // keep last compare result, rearm on invalid or reprogram
        if (cmp_valid && !wr_thr_ctrl) begin
            st_d.above_prev = above_now;
            st_d.above_valid = 1'b1;
        end else begin
            st_d.above_valid = 1'b0;
        end

        // shared pin: monitor or open-drain request
        if (st_q.ctrl[CTRL_IRQ_EN_BIT]) begin
            st_d.pin_o = st_q.ctrl[CTRL_IRQ_POL_BIT];
            st_d.pin_oe = pending;
        end else begin
            st_d.pin_o = monitor_pwm;
            st_d.pin_oe = 1'b1;
        end
    end

    // state register, synchronous active low reset
    always_ff @(posedge core_clk) begin : state_regs
        if (!resetn) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // pin drivers straight from flip-flops
    assign monitor_or_irq_pin_o = st_q.pin_o;
    assign monitor_or_irq_pin_oe = st_q.pin_oe;

endmodule : irq_thr_unit

//--- irq_thr_unit_props.sv
// bus handshake and pin checks of the interrupt and threshold unit
`timescale 1ns/10ps
module irq_thr_checker
    import irq_thr_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic monitor_or_irq_pin_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // handshake steps of the two bus directions
    sequence s_wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rd_take;
        arvalid && arready;
    endsequence
    sequence s_b_wait;
        bvalid && !bready;
    endsequence
    a_wr_answer_gap: assert property (s_wr_take |=> !bvalid ##1 bvalid)
        else $error("write answer not two cycles after take");
    a_rd_answer_next: assert property (s_rd_take |=> rvalid)
        else $error("read answer not in next cycle");
    a_b_held: assert property (s_b_wait |=> bvalid && $stable(bresp))
        else $error("write answer dropped early");
    a_r_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped or changed");
    a_ar_blocked: assert property (rvalid |-> !arready)
        else $error("read address taken while answer pending");
    a_w_blocked: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answer pending");
    a_b_drops: assert property (bvalid && bready |=> !bvalid)
        else $error("write answer repeated");
    a_r_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_pin_monitor_reset: assert property ($rose(resetn) |=> monitor_or_irq_pin_oe)
        else $error("pin not driven as monitor after reset");
endmodule : irq_thr_checker

bind irq_thr_unit irq_thr_checker i_chk (.*);

//--- irq_host_model.sv
// host side of the shared pin: pull resistor and interrupt input
`timescale 1ns/10ps
module irq_host_model (
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic pull_high,
    output logic pin_level,
    output logic irq_seen
);
    // released pin rests at the pull level
    assign pin_level = pin_oe ? pin_o : pull_high;
    // request seen when pin leaves the pull level; source found by polling
    assign irq_seen = pin_level != pull_high;
endmodule : irq_host_model

//--- testbench.sv
// self-checking bench of the interrupt and threshold unit
`timescale 1ns/10ps
module testbench;
    import irq_thr_pkg::*;
    logic core_clk, resetn, awvalid, awready, wvalid, wready, bvalid;
    logic bready, arvalid, arready, rvalid, rready, off_hook, monitor_pwm;
    logic line_side_capable, monitor_or_irq_pin_o, monitor_or_irq_pin_oe;
    logic lvl, seen, pull_high;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [7:1] source_events;
    logic [7:0] line_voltage_reading, fine_loop_current_reading;
    logic [31:0] s;
    int n_fail, n_compared;

    irq_thr_unit i_dut (.*, .monitor_or_irq_pin_i(lvl));
    irq_host_model i_host (.pin_o(monitor_or_irq_pin_o),
        .pin_oe(monitor_or_irq_pin_oe), .pull_high(pull_high),
        .pin_level(lvl), .irq_seen(seen));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    // magnitude of a reading, current unsigned
    function automatic logic [8:0] mag(input logic c, input logic [7:0] v);
        return (c || !v[7]) ? {1'b0, v} : 9'h100 - {1'b0, v};
    endfunction : mag

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic lapse(input int n);
        if (n > 50) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : lapse

    task automatic wr(input logic [5:0] i, logic [7:0] v,
            logic [1:0] e = RESP_OKAY);
        int n;
        logic a, w, b;
        logic [1:0] r;
        awaddr <= {i, 2'b00};
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(negedge core_clk);
            a = awready;
            w = wready;
            b = bvalid;
            r = bresp;
            @(posedge core_clk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            n++;
            lapse(n);
        end while (!b);
        // bready stays up so a following call never drives it twice
        chk("bresp", e, r);
    endtask : wr

    task automatic rd(input logic [5:0] i, logic [7:0] v,
            logic [1:0] e = RESP_OKAY);
        int n;
        logic a, b;
        logic [31:0] d;
        logic [1:0] r;
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(negedge core_clk);
            a = arready;
            b = rvalid;
            d = rdata;
            r = rresp;
            @(posedge core_clk);
            if (a) arvalid <= 1'b0;
            n++;
            lapse(n);
        end while (!b);
        // rready stays up so a following call never drives it twice
        chk("rdata", {24'h0, v}, d);
        chk("rresp", e, r);
    endtask : rd

    // pin drive and level as the host sees it
    task automatic pin(input logic oe, logic o, logic h);
        @(negedge core_clk);
        chk("pin", {oe, o}, {monitor_or_irq_pin_oe, monitor_or_irq_pin_o});
        if (h) chk("host irq", oe, seen);
        @(posedge core_clk);
    endtask : pin

    initial begin
        logic p, src, dir, f, hi;
        logic [7:0] lv, v, tc;
        s = 32'h7F83;
        p = 1'b0;
        {resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {off_hook, monitor_pwm, line_side_capable, pull_high} = '0;
        {awaddr, araddr, wdata, source_events} = '0;
        {line_voltage_reading, fine_loop_current_reading} = '0;
        wstrb = 4'h1;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        // reset values and an unmapped place
        rd(IDX_CTRL, CTRL_RESET);
        rd(IDX_MASK, MASK_RESET);
        rd(IDX_FLAGS, FLAGS_RESET);
        rd(IDX_THR_LEVEL, THR_LEVEL_RESET);
        rd(IDX_THR_CTRL, THR_CTRL_RESET);
        rd(6'h3F, 8'h00, RESP_SLVERR);
        wr(6'h3F, 8'hFF, RESP_SLVERR);
        // monitor stream reaches the pin a cycle late
        for (int k = 0; k < 8; k++) begin
            s = xs(s);
            monitor_pwm <= s[0];
            pin(1'b1, p, 1'b0);
            p = s[0];
        end
        // each of sources 1 to 7 with a random mask, both polarities; polarity detector not driven
        for (int k = 1; k < 8; k++) begin
            s = xs(s);
            pull_high <= ~k[0];
            wr(IDX_CTRL, {1'b1, k[0], 6'h00});
            wr(IDX_MASK, s[7:0]);
            source_events[k] <= 1'b1;
            @(posedge core_clk);
            source_events[k] <= 1'b0;
            repeat (2) @(posedge core_clk);
            pin(s[k], k[0], 1'b1);
            wr(IDX_FLAGS, 8'hFF);
            rd(IDX_FLAGS, 8'h01 << k);
            pin(s[k], k[0], 1'b1);
            wr(IDX_FLAGS, 8'h00);
            rd(IDX_FLAGS, 8'h00);
            pin(1'b0, k[0], 1'b1);
        end
        // threshold trials, the first without a capable line side
        wr(IDX_MASK, 8'h00);
        off_hook <= 1'b1;
        for (int t = 0; t < 8; t++) begin
            s = xs(s);
            line_side_capable <= (t != 0);
            src = s[8];
            dir = s[9];
            lv = {1'b0, s[6:0]};
            v = s[23:16];
            tc = {5'h00, src, 1'b1, dir};
            line_voltage_reading <= dir ? 8'h00 : 8'h80;
            fine_loop_current_reading <= dir ? 8'h00 : 8'h80;
            wr(IDX_THR_LEVEL, lv);
            wr(IDX_THR_CTRL, tc);
            repeat (2) @(posedge core_clk);
            if (src) fine_loop_current_reading <= v;
            else line_voltage_reading <= v;
            repeat (3) @(posedge core_clk);
            hi = mag(src, v) > {1'b0, lv};
            f = (t != 0) && ((mag(src, v) > {1'b0, lv}) == dir);
            rd(IDX_THR_CTRL, tc | {f, 3'h0});
            pin(f, 1'b1, 1'b1);
            rd(IDX_STATUS, {4'h0, hi && (t != 0), t != 0, f, f});
            rd(IDX_VOLTAGE, line_voltage_reading);
            rd(IDX_CURRENT, fine_loop_current_reading);
            wr(IDX_THR_CTRL, tc);
            repeat (3) @(posedge core_clk);
            rd(IDX_THR_CTRL, tc);
            wr(IDX_FLAGS, 8'h00);
        end
        tally_and_finish();
    end
endmodule : testbench
